// File: inc/vout_setpoint_pkg.sv
// Package of constants and carrier types for the output-voltage setpoint block.
package vout_setpoint_pkg;

    // ------------------------------------------------------------------
    // Register codes and field layout
    // ------------------------------------------------------------------
    localparam logic [7:0]  CMD_VOUT_FORMAT  = 8'h20;
    localparam logic [7:0]  CMD_VOUT_TARGET  = 8'h21;
    localparam logic [7:0]  CMD_VOUT_OFFSET  = 8'h22;
    localparam int          FMT_REL_BIT      = 7;
    localparam int          FMT_MODE_HI      = 6;
    localparam int          FMT_MODE_LO      = 5;
    localparam logic [1:0]  FMT_MODE_LINEAR  = 2'h0;
    localparam logic [4:0]  EXP_MIN          = 5'h14;   // -12 in two's complement.
    localparam logic [4:0]  EXP_MAX          = 5'h1C;   // -4 in two's complement.
    localparam logic [4:0]  NVM_TRIM_EXP     = 5'h14;   // Backup always at -12.
    localparam logic [15:0] TRIM_POS_LIMIT   = 16'h007F;
    localparam logic [15:0] TRIM_NEG_LIMIT   = 16'hFF81;
    localparam logic [7:0]  FMT_RESET        = 8'h17;   // Absolute, exponent -9.
    localparam logic [15:0] DAC_MAX_RESET    = 16'hFFFF;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        wr;      // Write strobe, one cycle.
        logic        rd;      // Read strobe, one cycle.
        logic [7:0]  cmd;     // Command code.
        logic [15:0] wdata;   // Write data word.
    } mgmt_req_t;

    typedef struct packed {
        logic        ack;     // Access accepted.
        logic        nack;    // Access refused.
        logic [15:0] rdata;   // Read data word.
    } mgmt_rsp_t;

    typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_RAMP} seq_state_t;

endpackage

// File: verilog/vout_setpoint_control.sv
// Output-voltage setpoint registers, conversion, limit clamping and ramp.
`timescale 1ns/1ps

module vout_setpoint_control (
    input  wire logic                          core_clk,        // Device clock, 40 MHz.
    input  wire logic                          reset_n,         // Asynchronous reset, active low.
    input  wire vout_setpoint_pkg::mgmt_req_t  req,             // Management bus request.
    output      vout_setpoint_pkg::mgmt_rsp_t  rsp,             // Management bus answer.
    input  wire logic                          conv_enable,     // Conversion enabled level.
    input  wire logic                          restore_all,     // Restore-all pulse.
    input  wire logic                          fault_restart,   // Hiccup restart pulse.
    input  wire logic                          reload_on_fault_sel, // Reload default on fault.
    input  wire logic                          strap_source_select_reg, // 1: strap default.
    input  wire logic [15:0]                   voltage_strap_pin, // Strap-decoded default.
    input  wire logic [15:0]                   nvm_target,      // Stored default target.
    input  wire logic [7:0]                    nvm_offset,      // Stored 8-bit offset.
    input  wire logic                          pgood_reset_mode, // Pin used as reset input.
    input  wire logic                          pgood_reset_pin, // Reset pin, active high here.
    input  wire logic [15:0]                   vout_max_lim,    // Maximum limit.
    input  wire logic [15:0]                   vout_min_lim,    // Minimum limit.
    input  wire logic [15:0]                   dac_hw_max,      // DAC hardware maximum.
    input  wire logic [15:0]                   step_per_clk,    // Ramp step per clock.
    output      logic [15:0]                   dac_code,        // Ramped reference code.
    output      logic [15:0]                   boot_voltage,    // Boot voltage copy.
    output      logic [7:0]                    nvm_offset_save, // Offset backup byte.
    output      logic                          limit_clamp_warning, // Limit warning flag.
    output      logic                          invalid_data,    // Invalid data flag.
    output      logic                          host_alert       // Alert pulse to host.
);
    import vout_setpoint_pkg::*;

    typedef struct packed {
        logic [7:0]  fmt;
        logic [15:0] target;
        logic [15:0] offset;
        logic [15:0] boot;
        logic [15:0] dac;
        logic [7:0]  save;
        logic        warn;
        logic        inval;
        logic        alert;
        logic        init_done;
        seq_state_t  st;
        mgmt_rsp_t   rsp;
    } state_t;

    state_t s_reg;
    state_t s_next;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Rescale a value from one exponent to another; signed for offsets.
    function automatic logic [15:0] rescale(input logic [15:0] v, input logic [4:0] from_e,
                                            input logic [4:0] to_e, input logic sgn);
        logic signed [5:0] d;
        logic [15:0]       r;
        d = $signed({from_e[4], from_e}) - $signed({to_e[4], to_e});
        if (d >= 0) begin
            r = v << d[3:0];
        end else if (sgn) begin
            r = 16'($signed(v) >>> (-d));
        end else begin
            r = v >> (-d);
        end
        return r;
    endfunction

    function automatic logic exp_ok(input logic [4:0] e);
        return (e >= EXP_MIN) && (e <= EXP_MAX);
    endfunction

    logic [16:0] sum_w;
    logic [15:0] goal_w;
    logic        over_max_w;
    logic        under_min_w;
    logic        over_dac_w;
    logic        trim_ok_w;
    logic [15:0] nvm_off_w;
    logic [15:0] default_w;
    logic [15:0] backup_w;
    logic        take_w;

    // Goal computed as target plus signed offset, then clamped.
    always_comb begin
        sum_w       = {1'b0, s_reg.target} + {s_reg.offset[15], s_reg.offset};
        over_max_w  = !sum_w[16] && (sum_w[15:0] > vout_max_lim);
        under_min_w = sum_w[16] || (sum_w[15:0] < vout_min_lim);
        over_dac_w  = !sum_w[16] && (sum_w[15:0] > dac_hw_max);
        if (over_dac_w) begin
            goal_w = dac_hw_max;
        end else if (over_max_w) begin
            goal_w = vout_max_lim;
        end else if (under_min_w) begin
            goal_w = vout_min_lim;
        end else begin
            goal_w = sum_w[15:0];
        end
        default_w = strap_source_select_reg ? voltage_strap_pin : nvm_target;
        nvm_off_w = rescale({{8{nvm_offset[7]}}, nvm_offset}, NVM_TRIM_EXP,
                            s_reg.fmt[4:0], 1'b1);
        trim_ok_w = ($signed(req.wdata) <= $signed(TRIM_POS_LIMIT)) &&
                    ($signed(req.wdata) >= $signed(TRIM_NEG_LIMIT));
        // A request is taken only when no reload event outranks it.
        take_w    = s_reg.init_done && !restore_all && !(pgood_reset_mode && pgood_reset_pin)
                    && !(fault_restart && reload_on_fault_sel);
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        s_next           = s_reg;
        s_next.rsp       = '0;
        s_next.alert     = 1'b0;
        // Load defaults once after reset, or on restore.
        if (!s_reg.init_done || restore_all) begin
            s_next.boot      = default_w;
            s_next.target    = default_w;
            s_next.offset    = nvm_off_w;
            s_next.init_done = 1'b1;
        end else if (pgood_reset_mode && pgood_reset_pin) begin
            s_next.target = s_reg.boot;
        end else if (fault_restart && reload_on_fault_sel) begin
            s_next.target = default_w;
        end else if (req.wr) begin
            if (req.cmd == CMD_VOUT_FORMAT) begin
                if (conv_enable || req.wdata[FMT_MODE_HI:FMT_MODE_LO] != FMT_MODE_LINEAR
                    || !exp_ok(req.wdata[4:0])) begin
                    s_next.rsp.nack = 1'b1;
                    s_next.inval    = 1'b1;
                end else begin
                    s_next.fmt    = {req.wdata[FMT_REL_BIT], FMT_MODE_LINEAR,
                                     req.wdata[4:0]};
                    s_next.target = rescale(s_reg.target, s_reg.fmt[4:0],
                                            req.wdata[4:0], 1'b0);
                    s_next.offset = rescale(s_reg.offset, s_reg.fmt[4:0],
                                            req.wdata[4:0], 1'b1);
                    s_next.rsp.ack = 1'b1;
                end
            end else if (req.cmd == CMD_VOUT_TARGET) begin
                s_next.target  = req.wdata;
                s_next.rsp.ack = 1'b1;
            end else if (req.cmd == CMD_VOUT_OFFSET) begin
                if (trim_ok_w) begin
                    s_next.offset  = req.wdata;
                    s_next.rsp.ack = 1'b1;
                end else begin
                    s_next.rsp.nack = 1'b1;
                    s_next.inval    = 1'b1;
                end
            end else begin
                s_next.rsp.nack = 1'b1;
            end
        end else if (req.rd) begin
            s_next.rsp.ack = 1'b1;
            if (req.cmd == CMD_VOUT_FORMAT) begin
                s_next.rsp.rdata = {8'h00, s_reg.fmt};
            end else if (req.cmd == CMD_VOUT_TARGET) begin
                s_next.rsp.rdata = s_reg.target;
            end else if (req.cmd == CMD_VOUT_OFFSET) begin
                s_next.rsp.rdata = s_reg.offset;
            end else begin
                s_next.rsp.ack  = 1'b0;
                s_next.rsp.nack = 1'b1;
            end
        end
        // Limit warning: raised on a crossing while converting, not if DAC limits.
        if (conv_enable && s_reg.init_done && (over_max_w || under_min_w) && !over_dac_w
            && !s_reg.warn) begin
            s_next.warn  = 1'b1;
            s_next.alert = 1'b1;
        end else if (!(over_max_w || under_min_w)) begin
            s_next.warn = 1'b0;
        end
        // Ramp the DAC toward the goal by a bounded step each clock.
        case (s_reg.st)
            ST_IDLE: begin
                if (s_reg.dac != goal_w) begin
                    s_next.st = ST_RAMP;
                end
            end
            ST_RAMP: begin
                if (s_reg.dac < goal_w) begin
                    s_next.dac = (goal_w - s_reg.dac > step_per_clk) ?
                                 s_reg.dac + step_per_clk : goal_w;
                end else if (s_reg.dac > goal_w) begin
                    s_next.dac = (s_reg.dac - goal_w > step_per_clk) ?
                                 s_reg.dac - step_per_clk : goal_w;
                end else begin
                    s_next.st = ST_IDLE;
                end
            end
            default: s_next.st = ST_IDLE;
        endcase
        // Backup byte: offset held at exponent -12 and saturated, whatever the format.
        backup_w = rescale(s_next.offset, s_next.fmt[4:0], NVM_TRIM_EXP, 1'b1);
        if ($signed(backup_w) > $signed(TRIM_POS_LIMIT)) begin
            s_next.save = TRIM_POS_LIMIT[7:0];
        end else if ($signed(backup_w) < $signed(TRIM_NEG_LIMIT)) begin
            s_next.save = TRIM_NEG_LIMIT[7:0];
        end else begin
            s_next.save = backup_w[7:0];
        end
        if (s_next.inval && !s_reg.inval) begin
            s_next.alert = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_reg     <= '0;
            s_reg.fmt <= FMT_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register.
    assign rsp                 = s_reg.rsp;
    assign dac_code            = s_reg.dac;
    assign boot_voltage        = s_reg.boot;
    assign nvm_offset_save     = s_reg.save;
    assign limit_clamp_warning = s_reg.warn;
    assign invalid_data        = s_reg.inval;
    assign host_alert          = s_reg.alert;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_fmt_mode;
        @(posedge core_clk) disable iff (!reset_n)
        s_reg.fmt[FMT_MODE_HI:FMT_MODE_LO] == FMT_MODE_LINEAR;
    endproperty
    a_fmt_mode: assert property (p_fmt_mode) else $error("Format mode not linear.");

    property p_fmt_locked;
        @(posedge core_clk) disable iff (!reset_n)
        (take_w && req.wr && req.cmd == CMD_VOUT_FORMAT && conv_enable)
        |=> rsp.nack && $stable(s_reg.fmt);
    endproperty
    a_fmt_locked: assert property (p_fmt_locked) else $error("Format written while on.");

    property p_exp_range;
        @(posedge core_clk) disable iff (!reset_n)
        s_reg.init_done |-> exp_ok(s_reg.fmt[4:0]);
    endproperty
    a_exp_range: assert property (p_exp_range) else $error("Exponent out of range.");

    property p_trim_nack;
        @(posedge core_clk) disable iff (!reset_n)
        (s_reg.init_done && !restore_all && !(pgood_reset_mode && pgood_reset_pin)
         && !(fault_restart && reload_on_fault_sel) && req.wr
         && req.cmd == CMD_VOUT_OFFSET && !trim_ok_w) |=> rsp.nack && invalid_data;
    endproperty
    a_trim_nack: assert property (p_trim_nack) else $error("Bad offset accepted.");

    property p_boot_hold;
        @(posedge core_clk) disable iff (!reset_n)
        (s_reg.init_done && !restore_all) |=> $stable(boot_voltage);
    endproperty
    a_boot_hold: assert property (p_boot_hold) else $error("Boot voltage changed.");

    property p_pin_reset;
        @(posedge core_clk) disable iff (!reset_n)
        (s_reg.init_done && !restore_all && pgood_reset_mode && pgood_reset_pin)
        |=> s_reg.target == $past(s_reg.boot);
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("Pin reset missed boot.");

    property p_dac_cap;
        @(posedge core_clk) disable iff (!reset_n)
        (s_reg.st == ST_RAMP && dac_code < goal_w) |=> dac_code <= $past(goal_w);
    endproperty
    a_dac_cap: assert property (p_dac_cap) else $error("Ramp overshoots goal.");

    property p_dac_silent;
        @(posedge core_clk) disable iff (!reset_n)
        (over_dac_w && !s_reg.warn) |=> !limit_clamp_warning;
    endproperty
    a_dac_silent: assert property (p_dac_silent) else $error("Warned on DAC clamp.");

    property p_warn_alert;
        @(posedge core_clk) disable iff (!reset_n)
        $rose(limit_clamp_warning) |-> host_alert;
    endproperty
    a_warn_alert: assert property (p_warn_alert) else $error("Warning without alert.");

    property p_target_write;
        @(posedge core_clk) disable iff (!reset_n)
        (take_w && req.wr && req.cmd == CMD_VOUT_TARGET)
        |=> rsp.ack && s_reg.target == $past(req.wdata);
    endproperty
    a_target_write: assert property (p_target_write) else $error("Target write lost.");

    property p_fmt_reject;
        @(posedge core_clk) disable iff (!reset_n)
        (take_w && req.wr && req.cmd == CMD_VOUT_FORMAT
         && (req.wdata[FMT_MODE_HI:FMT_MODE_LO] != FMT_MODE_LINEAR || !exp_ok(req.wdata[4:0])))
        |=> rsp.nack && invalid_data && $stable(s_reg.fmt);
    endproperty
    a_fmt_reject: assert property (p_fmt_reject) else $error("Bad format accepted.");

    property p_fault_keep;
        @(posedge core_clk) disable iff (!reset_n)
        (take_w && fault_restart && !req.wr) |=> $stable(s_reg.target);
    endproperty
    a_fault_keep: assert property (p_fault_keep) else $error("Fault restart lost target.");

    property p_restore_load;
        @(posedge core_clk) disable iff (!reset_n)
        restore_all |=> boot_voltage == $past(default_w) && s_reg.target == $past(default_w);
    endproperty
    a_restore_load: assert property (p_restore_load) else $error("Restore missed default.");

    property p_max_warn;
        @(posedge core_clk) disable iff (!reset_n)
        (conv_enable && s_reg.init_done && over_max_w && !over_dac_w && !s_reg.warn)
        |=> limit_clamp_warning && host_alert;
    endproperty
    a_max_warn: assert property (p_max_warn) else $error("Max crossing not warned.");

    c_fmt_write: cover property (@(posedge core_clk) disable iff (!reset_n)
        req.wr && req.cmd == CMD_VOUT_FORMAT && !conv_enable ##1 rsp.ack);
    c_ramp_done: cover property (@(posedge core_clk) disable iff (!reset_n)
        s_reg.st == ST_RAMP ##1 s_reg.st == ST_IDLE);
    c_warn: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(limit_clamp_warning));
    c_pin_reset: cover property (@(posedge core_clk) disable iff (!reset_n)
        pgood_reset_mode && pgood_reset_pin ##1 s_reg.target == s_reg.boot);
    c_trim_refused: cover property (@(posedge core_clk) disable iff (!reset_n)
        req.wr && req.cmd == CMD_VOUT_OFFSET && !trim_ok_w ##1 rsp.nack);

endmodule // vout_setpoint_control

// File: verification/mgmt_host_model.sv
// Management bus host model that issues single register transfers to the block.
`timescale 1ns/1ps
module mgmt_host_model (
    input  wire logic                         core_clk,   // Device clock.
    output      vout_setpoint_pkg::mgmt_req_t req,        // Request toward the block.
    input  wire vout_setpoint_pkg::mgmt_rsp_t rsp         // Answer from the block.
);
    import vout_setpoint_pkg::*;
    // -----------------------------------------------------------
    // Transfer task
    // -----------------------------------------------------------
    initial req = '0;

    // One transfer: strobe for one cycle, then sample the registered answer.
    task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [15:0] wdata,
                        output logic [15:0] rdata, output logic [1:0] resp);
        @(posedge core_clk);
        req <= '{wr: wr, rd: !wr, cmd: cmd, wdata: wdata};
        @(posedge core_clk);
        req <= '0;
        #1;
        rdata = rsp.rdata;
        resp  = {rsp.ack, rsp.nack};
    endtask
endmodule // mgmt_host_model

// File: verification/vout_setpoint_control_tb_top.sv
// Self-checking testbench of the output-voltage setpoint block.
`timescale 1ns/1ps
module vout_setpoint_control_tb_top;
    import vout_setpoint_pkg::*;
    // -----------------------------------------------------------
    // Stimulus and observation signals
    // -----------------------------------------------------------
    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    mgmt_req_t   req;
    mgmt_rsp_t   rsp;
    logic        conv_enable = 1'b1;
    logic        restore_all = 1'b0;
    logic        fault_restart = 1'b0;
    logic        reload_on_fault_sel = 1'b0;
    logic        strap_source_select_reg = 1'b0;
    logic [15:0] voltage_strap_pin = 16'h0A00;
    logic [15:0] nvm_target = 16'h0800;
    logic [7:0]  nvm_offset = 8'h00;
    logic        pgood_reset_mode = 1'b0;
    logic        pgood_reset_pin = 1'b0;
    logic [15:0] vout_max_lim = 16'h4000;
    logic [15:0] vout_min_lim = 16'h0100;
    logic [15:0] dac_hw_max = 16'h3000;
    logic [15:0] step_per_clk = 16'h0100;
    logic [15:0] dac_code, boot_voltage;
    logic [7:0]  nvm_offset_save;
    logic        limit_clamp_warning, invalid_data, host_alert;
    int          err_total = 0;
    int          checks_done = 0;
    int          alert_cnt = 0;
    int          a0;

    // Clock of 25 ns period.
    always #12.5 core_clk = ~core_clk;

    // Counts alert pulses so scenarios can tell whether one was sent.
    always @(posedge core_clk) begin
        if (host_alert === 1'b1) alert_cnt <= alert_cnt + 1;
    end

    vout_setpoint_control u_vout_setpoint_control (
        .core_clk(core_clk), .reset_n(reset_n), .req(req), .rsp(rsp),
        .conv_enable(conv_enable), .restore_all(restore_all), .fault_restart(fault_restart),
        .reload_on_fault_sel(reload_on_fault_sel),
        .strap_source_select_reg(strap_source_select_reg),
        .voltage_strap_pin(voltage_strap_pin), .nvm_target(nvm_target),
        .nvm_offset(nvm_offset), .pgood_reset_mode(pgood_reset_mode),
        .pgood_reset_pin(pgood_reset_pin), .vout_max_lim(vout_max_lim),
        .vout_min_lim(vout_min_lim), .dac_hw_max(dac_hw_max), .step_per_clk(step_per_clk),
        .dac_code(dac_code), .boot_voltage(boot_voltage), .nvm_offset_save(nvm_offset_save),
        .limit_clamp_warning(limit_clamp_warning), .invalid_data(invalid_data),
        .host_alert(host_alert)
    );

    mgmt_host_model u_mgmt_host_model (.core_clk(core_clk), .req(req), .rsp(rsp));

    // -----------------------------------------------------------
    // Shared tasks
    // -----------------------------------------------------------
    // Compares a seen value with the expected one and reports a mismatch.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Writes a register and checks the answer code: 2'b10 ack, 2'b01 nack.
    task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input logic [1:0] exp);
        logic [15:0] rd_v;
        logic [1:0]  rs;
        u_mgmt_host_model.xfer(1'b1, cmd, d, rd_v, rs);
        check("write answer", {14'h0, rs}, {14'h0, exp});
    endtask

    // Reads a register and checks the data returned with the ack.
    task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
        logic [15:0] rd_v;
        logic [1:0]  rs;
        u_mgmt_host_model.xfer(1'b0, cmd, 16'h0000, rd_v, rs);
        check("read answer", {14'h0, rs}, 16'h0002);
        check("read data", rd_v, exp);
    endtask

    // Waits a bounded time for the ramp to reach a code.
    task automatic wait_dac(input logic [15:0] exp);
        for (int i = 0; i < 400 && dac_code !== exp; i++) @(posedge core_clk);
        #1;
        check("dac code", dac_code, exp);
    endtask

    // Raises one of the event inputs for one cycle: 0 restore, 1 fault, 2 reset pin.
    task automatic kick(input int sel);
        @(posedge core_clk);
        case (sel)
            0: restore_all <= 1'b1;
            1: fault_restart <= 1'b1;
            default: pgood_reset_pin <= 1'b1;
        endcase
        @(posedge core_clk);
        restore_all <= 1'b0;
        fault_restart <= 1'b0;
        pgood_reset_pin <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("Checks made: %0d, mismatches: %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Cuts a hang short well past the expected run length.
    initial begin
        #(25ns * 20000);
        err_total++;
        test_done();
    end

    // -----------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------
    initial begin
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        wait_dac(16'h0800);
        rd(CMD_VOUT_FORMAT, {8'h00, FMT_RESET});
        rd(CMD_VOUT_TARGET, 16'h0800);
        check("boot", boot_voltage, 16'h0800);
        wr(CMD_VOUT_TARGET, 16'h1000, 2'b10);
        check("boot kept", boot_voltage, 16'h0800);
        repeat (2) @(posedge core_clk);
        #1 check("ramping", {15'h0, dac_code === 16'h1000}, 16'h0000);
        wait_dac(16'h1000);
        wr(CMD_VOUT_OFFSET, 16'h007F, 2'b10);
        check("backup", {8'h00, nvm_offset_save}, 16'h007F);
        wr(CMD_VOUT_OFFSET, 16'h0080, 2'b01);
        check("invalid", {15'h0, invalid_data}, 16'h0001);
        wr(CMD_VOUT_OFFSET, 16'hFF81, 2'b10);
        wr(CMD_VOUT_OFFSET, 16'hFF80, 2'b01);
        rd(CMD_VOUT_OFFSET, 16'hFF81);
        check("backup", {8'h00, nvm_offset_save}, 16'h0081);
        wait_dac(16'h0F81);
        wr(CMD_VOUT_OFFSET, 16'h007F, 2'b10);
        wr(CMD_VOUT_TARGET, 16'h2FF0, 2'b10);
        wait_dac(16'h3000);
        check("no warn", {15'h0, limit_clamp_warning}, 16'h0000);
        @(posedge core_clk);
        dac_hw_max <= 16'hFFFF;
        a0 = alert_cnt;
        wr(CMD_VOUT_TARGET, 16'h4100, 2'b10);
        wait_dac(16'h4000);
        check("max warn", {15'h0, limit_clamp_warning}, 16'h0001);
        check("alert", {15'h0, alert_cnt > a0}, 16'h0001);
        wr(CMD_VOUT_TARGET, 16'h1000, 2'b10);
        wait_dac(16'h107F);
        check("warn clear", {15'h0, limit_clamp_warning}, 16'h0000);
        a0 = alert_cnt;
        wr(CMD_VOUT_TARGET, 16'h0010, 2'b10);
        wait_dac(16'h0100);
        check("min warn", {15'h0, limit_clamp_warning}, 16'h0001);
        check("min alert", {15'h0, alert_cnt > a0}, 16'h0001);
        wr(CMD_VOUT_TARGET, 16'h1000, 2'b10);
        wait_dac(16'h107F);
        check("warn gone", {15'h0, limit_clamp_warning}, 16'h0000);
        wr(8'h23, 16'h0000, 2'b01);
        wr(CMD_VOUT_FORMAT, 16'h0016, 2'b01);
        rd(CMD_VOUT_FORMAT, 16'h0017);
        @(posedge core_clk);
        conv_enable <= 1'b0;
        wr(CMD_VOUT_FORMAT, 16'h0037, 2'b01);
        wr(CMD_VOUT_FORMAT, 16'h0013, 2'b01);
        wr(CMD_VOUT_FORMAT, 16'h001D, 2'b01);
        wr(CMD_VOUT_FORMAT, 16'h0016, 2'b10);
        rd(CMD_VOUT_TARGET, 16'h2000);
        rd(CMD_VOUT_OFFSET, 16'h00FE);
        wr(CMD_VOUT_TARGET, 16'h0800, 2'b10);
        wr(CMD_VOUT_FORMAT, 16'h0017, 2'b10);
        rd(CMD_VOUT_TARGET, 16'h0400);
        rd(CMD_VOUT_OFFSET, 16'h007F);
        wr(CMD_VOUT_FORMAT, 16'h0014, 2'b10);
        check("backup sat", {8'h00, nvm_offset_save}, 16'h007F);
        wr(CMD_VOUT_FORMAT, 16'h001C, 2'b10);
        wr(CMD_VOUT_FORMAT, 16'h0017, 2'b10);
        rd(CMD_VOUT_TARGET, 16'h0400);
        wr(CMD_VOUT_FORMAT, 16'h0097, 2'b10);
        rd(CMD_VOUT_FORMAT, 16'h0097);
        wr(CMD_VOUT_FORMAT, 16'h0017, 2'b10);
        @(posedge core_clk);
        strap_source_select_reg <= 1'b1;
        kick(0);
        rd(CMD_VOUT_TARGET, 16'h0A00);
        check("boot strap", boot_voltage, 16'h0A00);
        wr(CMD_VOUT_TARGET, 16'h0C00, 2'b10);
        @(posedge core_clk);
        pgood_reset_mode <= 1'b1;
        kick(2);
        rd(CMD_VOUT_TARGET, 16'h0A00);
        @(posedge core_clk);
        pgood_reset_mode <= 1'b0;
        wr(CMD_VOUT_TARGET, 16'h0C00, 2'b10);
        kick(1);
        rd(CMD_VOUT_TARGET, 16'h0C00);
        @(posedge core_clk);
        reload_on_fault_sel <= 1'b1;
        kick(1);
        rd(CMD_VOUT_TARGET, 16'h0A00);
        test_done();
    end
endmodule // vout_setpoint_control_tb_top
